// [verification/tb_uart_int_ident_fifo_ctrl.sv]
`include "uart_ident_cfg.svh"
module tb_uart_int_ident_fifo_ctrl;
  import uart_ident_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, hold_on = 1'b0;
  logic        rxf, txf, qon, pend, drq, dtq, drs, dts, rts_n;
  logic [7:0]  rdata, v;
  logic [3:0]  code;
  logic [4:0]  rx_set = 5'h0_0, tx_set = 5'h0_1, rx_count, tx_count;
  reg_req_t    req_s = '0;
  int_src_t    src_s = '0;
  int          miscompares = 0, comparisons = 0, cycles = 0;
  int          rl [4] = '{1, 4, 8, 14};
  int          tl [4] = '{0, 2, 4, 8};
  logic [16:0] tbl [6] = '{{3'b000, 5'd0, 5'd1, 4'h1}, {3'b111, 5'd1, 5'd0, 4'h6},
    {3'b011, 5'd1, 5'd0, 4'h4}, {3'b011, 5'd0, 5'd0, 4'hc}, {3'b001, 5'd0, 5'd0, 4'h2},
    {3'b001, 5'd0, 5'd1, 4'h0}};
  uart_int_ident_fifo_ctrl dut (.clk(clk), .rst(rst), .req(req_s), .rdata(rdata),
    .rx_count(rx_count), .tx_count(tx_count), .src(src_s), .rx_flush(rxf), .tx_flush(txf),
    .queues_on_flag(qon), .int_source_code(code), .int_pending(pend), .dma_rx_req_n(drq),
    .dma_tx_req_n(dtq), .dma_rx_single_n(drs), .dma_tx_single_n(dts), .rts_n(rts_n));
  uart_ident_remote far (.clk(clk), .rx_flush(rxf), .tx_flush(txf), .rts_n(rts_n),
    .hold_on(hold_on), .rx_set(rx_set), .tx_set(tx_set), .rx_count(rx_count),
    .tx_count(tx_count));
  // ----
  // access tasks
  // ----
  task automatic print_verdict;
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req_s <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req_s.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    req_s <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    req_s.rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // four edges cover the far side's edge plus the design's registered lag
  task automatic cfg(input logic [2:0] s, input logic [4:0] r, input logic [4:0] t);
    @(posedge clk);
    src_s <= s;
    rx_set <= r;
    tx_set <= t;
    repeat (4) @(posedge clk);
  endtask
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      print_verdict;
    end
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (12) @(posedge clk);
    chk({drq, dtq, drs, dts, rts_n, qon, 2'b00}, 8'hf8);
    rst <= 1'b0;
    rd(`OFF_IDENT_QCTRL);
    chk(v, `IDENT_RESET);
    rd(4'h3);
    chk(v, 8'h00);
    wr(`OFF_IDENT_QCTRL, 8'h01);
    chk({6'h00, txf, rxf}, 8'h03);
    wr(`OFF_IDENT_QCTRL, 8'h03);
    chk({6'h00, txf, rxf}, 8'h01);
    wr(`OFF_IDENT_QCTRL, 8'h05);
    chk({6'h00, txf, rxf}, 8'h02);
    rd(`OFF_IDENT_QCTRL);
    chk(v, 8'hc1);
    chk({7'h00, qon}, 8'h01);
    wr(`OFF_INT_ENABLE, 8'h0f);
    foreach (tbl[i]) begin
      cfg(tbl[i][16:14], tbl[i][13:9], tbl[i][8:4]);
      rd(`OFF_IDENT_QCTRL);
      chk(v, {4'hc, tbl[i][3:0]});
    end
    wr(`OFF_MODEM_CTRL, 8'h22);
    hold_on <= 1'b1;
    for (int l = 0; l < 4; l++) begin
      wr(`OFF_IDENT_QCTRL, {l[1:0], 6'b001001});
      cfg(3'b000, 5'(rl[l] - 1), 5'd1);
      rd(`OFF_IDENT_QCTRL);
      chk({v[3:0], 2'b00, rts_n, drq}, 8'h11);
      cfg(3'b000, 5'(rl[l]), 5'd1);
      rd(`OFF_IDENT_QCTRL);
      chk({v[3:0], 2'b00, rts_n, drq}, 8'h42);
      chk({6'h00, drs, pend}, 8'h01);
    end
    wr(`OFF_INT_ENABLE, 8'h82);
    for (int l = 0; l < 4; l++) begin
      wr(`OFF_IDENT_QCTRL, {2'b00, l[1:0], 4'b1001});
      cfg(3'b000, 5'd0, 5'(tl[l] + 1));
      rd(`OFF_IDENT_QCTRL);
      chk({v[3:0], 3'b000, dtq}, 8'h11);
      cfg(3'b000, 5'd0, 5'(tl[l]));
      rd(`OFF_IDENT_QCTRL);
      chk({v[3:0], 3'b000, dtq}, 8'h20);
    end
    wr(`OFF_INT_ENABLE, 8'h02);
    cfg(3'b000, 5'd0, 5'd2);
    rd(`OFF_IDENT_QCTRL);
    chk(v, 8'hc1);
    chk({6'h00, dts, pend}, 8'h00);
    print_verdict;
  end
endmodule

// [verification/uart_ident_monitor.sv]
`include "uart_ident_cfg.svh"
module uart_ident_monitor (
  input wire logic                     clk,
  input wire logic                     rst,
  input wire uart_ident_pkg::reg_req_t req,
  input wire logic [7:0]               rdata,
  input wire logic                     rx_flush,
  input wire logic                     tx_flush,
  input wire logic [3:0]               int_source_code,
  input wire logic                     int_pending,
  input wire logic                     dma_rx_req_n,
  input wire logic                     dma_rx_single_n,
  input wire logic                     dma_tx_req_n,
  input wire logic                     dma_tx_single_n
);
  import uart_ident_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // port checks
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wq = req.wr && req.addr == `OFF_IDENT_QCTRL;
  code_legal_a: assert property (int_source_code inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hc})
    else $error("illegal source code");
  pending_tie_a: assert property (int_pending == (int_source_code != `CODE_NONE))
    else $error("pending flag disagrees with code");
  ident_fields_a: assert property (req.rd && req.addr == `OFF_IDENT_QCTRL
    |=> rdata[5:4] == 2'b00 && rdata[7] == rdata[6]) else $error("ident upper bits wrong");
  rdata_idle_a: assert property (!req.rd |=> rdata == 8'h00)
    else $error("read data without read");
  rx_flush_a: assert property (wq && req.wdata[1] |=> rx_flush) else $error("rx flush missing");
  tx_flush_a: assert property (wq && req.wdata[2] |=> tx_flush) else $error("tx flush missing");
  flush_pulse_a: assert property ((rx_flush || tx_flush) && !req.wr |=> !rx_flush && !tx_flush)
    else $error("flush longer than one cycle");
  rx_dma_drop_a: assert property (rx_flush |=> dma_rx_req_n && dma_rx_single_n)
    else $error("rx dma active after flush");
  tx_dma_drop_a: assert property (tx_flush |=> dma_tx_req_n && dma_tx_single_n)
    else $error("tx dma active after flush");
endmodule

bind uart_int_ident_fifo_ctrl uart_ident_monitor mon (.clk(clk), .rst(rst), .req(req),
  .rdata(rdata), .rx_flush(rx_flush), .tx_flush(tx_flush), .int_source_code(int_source_code),
  .int_pending(int_pending), .dma_rx_req_n(dma_rx_req_n), .dma_rx_single_n(dma_rx_single_n),
  .dma_tx_req_n(dma_tx_req_n), .dma_tx_single_n(dma_tx_single_n));

// [verification/uart_ident_remote.sv]
module uart_ident_remote (
  input  wire logic       clk,
  input  wire logic       rx_flush,
  input  wire logic       tx_flush,
  input  wire logic       rts_n,
  input  wire logic       hold_on,
  input  wire logic [4:0] rx_set,
  input  wire logic [4:0] tx_set,
  output logic      [4:0] rx_count,
  output logic      [4:0] tx_count
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // far side fill
  // ----
  initial rx_count = 5'h0_0;
  initial tx_count = 5'h0_1;
  // the remote stops sending while request-to-send is dropped in auto mode
  always @(posedge clk) begin
    if (rx_flush) rx_count <= 5'h0_0;
    else if (!(hold_on && rts_n && rx_set > rx_count)) rx_count <= rx_set;
    tx_count <= tx_flush ? 5'h0_0 : tx_set;
  end
endmodule

// [verilog/uart_ident_cfg.svh]
`ifndef UART_IDENT_CFG_SVH
`define UART_IDENT_CFG_SVH

// register locations on the plain register port
`define ADDR_W              4
`define OFF_IDENT_QCTRL     4'h2
`define OFF_INT_ENABLE      4'h1
`define OFF_MODEM_CTRL      4'h4
`define OFF_QUEUE_STATUS    4'h7

// read view layout and reset value
`define IDENT_RESET         8'h01
`define IDENT_CODE_LSB      0
`define IDENT_ON_LSB        6

// write view field positions
`define QC_ENABLE_BIT       0
`define QC_RX_FLUSH_BIT     1
`define QC_TX_FLUSH_BIT     2
`define QC_DMA_MODE_BIT     3
`define QC_TX_LEVEL_LSB     4
`define QC_RX_LEVEL_LSB     6

// interrupt enable bits
`define IE_RX_DATA_BIT      0
`define IE_TX_EMPTY_BIT     1
`define IE_LINE_BIT         2
`define IE_MODEM_BIT        3
`define IE_PROG_TX_BIT      7

// modem control bits
`define MC_RTS_BIT          1
`define MC_AUTO_BIT         5

// source codes
`define CODE_MODEM          4'h0
`define CODE_NONE           4'h1
`define CODE_TX_EMPTY       4'h2
`define CODE_RX_DATA        4'h4
`define CODE_LINE           4'h6
`define CODE_TIMEOUT        4'hc

`endif

// [verilog/uart_ident_pkg.sv]
package uart_ident_pkg;

  typedef enum logic [1:0] {
    TX_LVL_EMPTY,
    TX_LVL_TWO,
    TX_LVL_QUARTER,
    TX_LVL_HALF
  } tx_level_t;

  typedef enum logic [1:0] {
    RX_LVL_ONE,
    RX_LVL_QUARTER,
    RX_LVL_HALF,
    RX_LVL_NEAR_FULL
  } rx_level_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic line_status;
    logic char_timeout;
    logic modem_status;
  } int_src_t;

endpackage

// [verilog/uart_int_ident_fifo_ctrl.sv]
// Contract
// [R1] ident on read, queue control on write
// [R2] bits 3:0 name top pending interrupt
// [R3] code 0001 when nothing pending
// [R4] modem 0000, transmit empty 0010
// [R5] rx data 0100, line status 0110
// [R6] character timeout reports 1100
// [R7] busy detect code never produced
// [R8] bits 5:4 read zero
// [R9] bits 7:6 show queues on
// [R10] read view 0x01 after reset
// [R11] control values are not read back; enable and dma mode read at queue status
// [R12] bit 0 enables; change flushes both
// [R13] bit 1 flushes rx, drops rx dma
// [R14] bit 2 flushes tx, drops tx dma
// [R15] bits 5:4 set tx empty level
// [R16] tx level: empty, two, quarter, half
// [R17] tx level steers tx dma request
// [R18] rx data interrupt at rx level
// [R19] rx level: one, quarter, half, full-2
// [R20] auto flow drops rts at rx level
// [R21] rx level steers rx dma request
// [R22] tx level used when prog mode on
// [R23] auto flow needs queues and enable
// [R24] flushes are single-cycle pulses
// [R25] dma mode bit stored, picks signalling
//
// Design decisions made here: the strobed register port and the register addresses.
`include "uart_ident_cfg.svh"

module uart_int_ident_fifo_ctrl #(
  parameter int DEPTH = 16,
  parameter int CNT_W = 5
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire uart_ident_pkg::reg_req_t req,
  output logic [7:0]                 rdata,
  input  wire logic [CNT_W-1:0]      rx_count,
  input  wire logic [CNT_W-1:0]      tx_count,
  input  wire uart_ident_pkg::int_src_t src,
  output logic                       rx_flush,
  output logic                       tx_flush,
  output logic                       queues_on_flag,
  output logic [3:0]                 int_source_code,
  output logic                       int_pending,
  output logic                       dma_rx_req_n,
  output logic                       dma_tx_req_n,
  output logic                       dma_rx_single_n,
  output logic                       dma_tx_single_n,
  output logic                       rts_n
);
  import uart_ident_pkg::*;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic       queue_enable_r;
  logic       dma_signal_mode_r;
  tx_level_t  tx_empty_level_r;
  rx_level_t  rx_fill_level_r;
  logic [7:0] int_enable_r;
  logic [7:0] modem_ctrl_r;
  logic       rx_flush_r;
  logic       tx_flush_r;

  // ---------------------------------------------------------------
  // level marks
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] MARK_TWO     = CNT_W'(2);
  localparam logic [CNT_W-1:0] MARK_QUARTER = CNT_W'(DEPTH / 4);
  localparam logic [CNT_W-1:0] MARK_HALF    = CNT_W'(DEPTH / 2);
  localparam logic [CNT_W-1:0] MARK_NEAR    = CNT_W'(DEPTH - 2);
  localparam logic [CNT_W-1:0] MARK_FULL    = CNT_W'(DEPTH);

  // one location: reads give the ident view, writes the queue control
  wire wr_qc = req.wr && (req.addr == `OFF_IDENT_QCTRL);  // R1 R11
  wire wr_ie = req.wr && (req.addr == `OFF_INT_ENABLE);
  wire wr_mc = req.wr && (req.addr == `OFF_MODEM_CTRL);

  // ---------------------------------------------------------------
  // queue control fields
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      queue_enable_r <= 1'b0;
    end else if (wr_qc) begin
      queue_enable_r <= req.wdata[`QC_ENABLE_BIT];  // R12
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_signal_mode_r <= 1'b0;
    end else if (wr_qc) begin
      dma_signal_mode_r <= req.wdata[`QC_DMA_MODE_BIT];  // R25
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_empty_level_r <= TX_LVL_EMPTY;
    end else if (wr_qc) begin
      tx_empty_level_r <= tx_level_t'(req.wdata[`QC_TX_LEVEL_LSB +: 2]);  // R15
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_fill_level_r <= RX_LVL_ONE;
    end else if (wr_qc) begin
      rx_fill_level_r <= rx_level_t'(req.wdata[`QC_RX_LEVEL_LSB +: 2]);  // R18
    end
  end

  // ---------------------------------------------------------------
  // neighbour registers
  // ---------------------------------------------------------------
  // copies of the neighbour registers whose bits steer this block
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_enable_r <= 8'h00;
    end else if (wr_ie) begin
      int_enable_r <= req.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modem_ctrl_r <= 8'h00;
    end else if (wr_mc) begin
      modem_ctrl_r <= req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // flush pulses
  // ---------------------------------------------------------------
  // an enable toggle flushes both queues so stale pointers never survive
  wire en_change = wr_qc && (req.wdata[`QC_ENABLE_BIT] != queue_enable_r);  // R12

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_flush_r <= 1'b0;
    end else begin
      rx_flush_r <= wr_qc && (req.wdata[`QC_RX_FLUSH_BIT] || en_change);  // R13 R24
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_flush_r <= 1'b0;
    end else begin
      tx_flush_r <= wr_qc && (req.wdata[`QC_TX_FLUSH_BIT] || en_change);  // R14 R24
    end
  end

  // ---------------------------------------------------------------
  // level decoding
  // ---------------------------------------------------------------
  function automatic logic [CNT_W-1:0] rx_mark(input rx_level_t l);
    case (l)  // R19
      RX_LVL_ONE:       rx_mark = CNT_W'(1);
      RX_LVL_QUARTER:   rx_mark = MARK_QUARTER;
      RX_LVL_HALF:      rx_mark = MARK_HALF;
      RX_LVL_NEAR_FULL: rx_mark = MARK_NEAR;
      default:          rx_mark = CNT_W'(1);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] tx_mark(input tx_level_t l);
    case (l)  // R16
      TX_LVL_EMPTY:   tx_mark = CNT_W'(0);
      TX_LVL_TWO:     tx_mark = MARK_TWO;
      TX_LVL_QUARTER: tx_mark = MARK_QUARTER;
      TX_LVL_HALF:    tx_mark = MARK_HALF;
      default:        tx_mark = CNT_W'(0);
    endcase
  endfunction

  // marks decoded once; interrupt, dma and flow paths share them
  wire [CNT_W-1:0] rx_mark_w = rx_mark(rx_fill_level_r);  // R19
  wire [CNT_W-1:0] tx_mark_w = tx_mark(tx_empty_level_r);  // R16
  wire             prog_tx   = queue_enable_r && int_enable_r[`IE_PROG_TX_BIT];  // R22

  // ---------------------------------------------------------------
  // level hits
  // ---------------------------------------------------------------
  // with queues off a single holding slot behaves as depth one
  logic rx_hit;
  always_comb begin
    if (queue_enable_r) begin
      rx_hit = (rx_count >= rx_mark_w);  // R18
    end else begin
      rx_hit = (rx_count != '0);
    end
  end

  // programmable mode fires at the level, otherwise only when empty
  logic tx_hit;
  always_comb begin
    if (prog_tx) begin
      tx_hit = (tx_count <= tx_mark_w);  // R15 R22
    end else begin
      tx_hit = (tx_count == '0);
    end
  end

  logic tx_dma_hit;
  always_comb begin
    if (queue_enable_r) begin
      tx_dma_hit = (tx_count <= tx_mark_w);  // R17
    end else begin
      tx_dma_hit = (tx_count == '0);
    end
  end

  // ---------------------------------------------------------------
  // interrupt priority
  // ---------------------------------------------------------------
  // each cause is gated by its enable bit (timeout shares the rx data one) before priority is applied
  wire line_on = int_enable_r[`IE_LINE_BIT] && src.line_status;
  wire rxd_on  = int_enable_r[`IE_RX_DATA_BIT] && rx_hit;
  wire tmo_on  = int_enable_r[`IE_RX_DATA_BIT] && src.char_timeout;
  wire txe_on  = int_enable_r[`IE_TX_EMPTY_BIT] && tx_hit;
  wire mdm_on  = int_enable_r[`IE_MODEM_BIT] && src.modem_status;

  // ---------------------------------------------------------------
  // priority pick
  // ---------------------------------------------------------------
  // line errors outrank data so a bad byte is reported before it is taken
  logic [3:0] code_nxt;
  always_comb begin
    code_nxt = `CODE_NONE;  // R3 R7
    if (line_on) begin
      code_nxt = `CODE_LINE;  // R5
    end else if (rxd_on) begin
      code_nxt = `CODE_RX_DATA;  // R5
    end else if (tmo_on) begin
      code_nxt = `CODE_TIMEOUT;  // R6
    end else if (txe_on) begin
      code_nxt = `CODE_TX_EMPTY;  // R4
    end else if (mdm_on) begin
      code_nxt = `CODE_MODEM;  // R4
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_source_code <= `CODE_NONE;  // R10
    end else begin
      int_source_code <= code_nxt;  // R2
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_pending <= 1'b0;
    end else begin
      int_pending <= (code_nxt != `CODE_NONE);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      queues_on_flag <= 1'b0;  // R10
    end else begin
      queues_on_flag <= queue_enable_r;  // R9
    end
  end

  // ---------------------------------------------------------------
  // dma request lines, active low
  // ---------------------------------------------------------------
  // mode 0 asks per character, mode 1 asks by level; a flush drops both
  logic rx_req_want;
  always_comb begin
    case (dma_signal_mode_r)  // R25
      1'b0:    rx_req_want = (rx_count != '0);
      default: rx_req_want = rx_hit;  // R21
    endcase
  end

  logic tx_req_want;
  always_comb begin
    case (dma_signal_mode_r)  // R25
      1'b0:    tx_req_want = (tx_count == '0);
      default: tx_req_want = tx_dma_hit;  // R17
    endcase
  end

  // ---------------------------------------------------------------
  // request line flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_rx_single_n <= 1'b1;
    end else begin
      dma_rx_single_n <= rx_flush_r || (rx_count == '0);  // R13
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_rx_req_n <= 1'b1;
    end else begin
      dma_rx_req_n <= rx_flush_r || !rx_req_want;  // R13 R21
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_tx_single_n <= 1'b1;
    end else begin
      dma_tx_single_n <= tx_flush_r || (tx_count >= MARK_FULL);  // R14
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_tx_req_n <= 1'b1;
    end else begin
      dma_tx_req_n <= tx_flush_r || !tx_req_want;  // R14 R17
    end
  end

  // ---------------------------------------------------------------
  // request-to-send
  // ---------------------------------------------------------------
  // software's own request, overridden only while auto flow runs
  wire rts_soft = modem_ctrl_r[`MC_RTS_BIT];
  wire auto_on  = queue_enable_r && modem_ctrl_r[`MC_AUTO_BIT];  // R23
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rts_n <= 1'b1;
    end else if (auto_on) begin
      rts_n <= !rts_soft || rx_hit;  // R20
    end else begin
      rts_n <= !rts_soft;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // the view is rebuilt from live state; the control byte is never stored
  function automatic logic [7:0] ident_view(input logic [3:0] code, input logic on);
    ident_view = {{2{on}}, 2'b00, code};  // R8 R9
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        // level and flush controls never appear here; queue status shows the enable and dma mode bits
        `OFF_IDENT_QCTRL:  rdata <= ident_view(code_nxt, queue_enable_r);  // R1 R11
        `OFF_INT_ENABLE:   rdata <= int_enable_r;
        `OFF_MODEM_CTRL:   rdata <= modem_ctrl_r;
        `OFF_QUEUE_STATUS: rdata <= {6'h00, dma_signal_mode_r, queue_enable_r};
        default:           rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // flush outputs
  // ---------------------------------------------------------------
  // pulses leave straight from their flops so the queues see clean edges
  assign rx_flush = rx_flush_r;  // R24
  assign tx_flush = tx_flush_r;  // R24

endmodule
